// ---- shared/ecc_pkg.sv ----
// package for encoder compare and capture control: map, fields, reset values, counts
package ecc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ECC_OFS_CMP_CTL  = 8'h00; // position_compare_control
  localparam logic [7:0] ECC_OFS_CAP_CTL  = 8'h04; // capture_control
  localparam logic [7:0] ECC_OFS_CMP_VAL  = 8'h08; // position_compare_value
  localparam logic [7:0] ECC_OFS_IRQ_STAT = 8'h0C; // sticky event flags, write one to clear
  localparam logic [7:0] ECC_OFS_IRQ_MASK = 8'h10; // interrupt enables
  localparam logic [7:0] ECC_OFS_STATE    = 8'h14; // live block state, read only

  // position_compare_control fields
  localparam int ECC_PC_SHDW_BIT = 15;
  localparam int ECC_PC_LOAD_BIT = 14;
  localparam int ECC_PC_POL_BIT  = 13;
  localparam int ECC_PC_EN_BIT   = 12;
  localparam int ECC_PC_SPW_MSB  = 11;
  localparam int ECC_PC_SPW_LSB  = 0;

  // capture_control fields
  localparam int ECC_CAP_EN_BIT   = 15;
  localparam int ECC_CAP_CAPTURE_CLOCK_PRESCALE_MSB = 6;
  localparam int ECC_CAP_CAPTURE_CLOCK_PRESCALE_LSB = 4;
  localparam int ECC_CAP_UNIT_POSITION_PRESCALE_MSB = 3;
  localparam int ECC_CAP_UNIT_POSITION_PRESCALE_LSB = 0;
  localparam logic [15:0] ECC_CAP_WMASK = 16'h807F; // bits 14..7 held at zero

  // interrupt flag positions
  localparam int ECC_IRQ_MATCH = 0; // compare match
  localparam int ECC_IRQ_SHLD  = 1; // shadow transferred to active
  localparam int ECC_IRQ_UPEV  = 2; // unit position event
  localparam int ECC_IRQ_W     = 3;

  // reset values
  localparam logic [15:0]       ECC_RST_CMP_CTL = 16'h0000;
  localparam logic [15:0]       ECC_RST_CAP_CTL = 16'h0000;
  localparam logic [31:0]       ECC_RST_CMP_VAL = 32'h0000_0000;
  localparam logic [ECC_IRQ_W-1:0] ECC_RST_IRQ  = 3'h0;

  // counts
  localparam int ECC_SPW_QUANTUM  = 4;    // system clocks per width step
  localparam int ECC_STRETCH_W    = 14;   // holds 4096*4-1
  localparam int ECC_CAPTURE_CLOCK_PRESCALE_DIV_W   = 7;    // up to divide by 128
  localparam int ECC_UNIT_POSITION_PRESCALE_DIV_W   = 11;   // up to divide by 2048
  localparam logic [3:0] ECC_UNIT_POSITION_PRESCALE_MAX = 4'hB; // codes above are reserved

  // apb answer state
  typedef enum logic [0:0] {ECC_APB_IDLE = 1'b0, ECC_APB_ACK = 1'b1} ecc_apb_st_t;

endpackage

// ---- rtl/ecc_top.sv ----
// encoder position compare unit and capture prescalers behind an apb slave
//
// Notes on behaviour
// - shadow off writes compare directly, else shadow
// - load mode picks counter zero or compare match
// - polarity bit one makes sync pulse active low
// - compare enable low stops matches and pulses
// - pulse lasts (width field plus one) times four
// - capture enable bit fifteen gates capture unit
// - capture clock is system clock over two-power
// - unit event divides quadrature clock, 11xx reserved
// - compare equal to counter raises sync and flag
module ecc_top
  import ecc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] position_counter,
  input  wire logic        quadrature_clock,
  output logic             sync_out,
  output logic             compare_match,
  output logic             capture_timer_clock,
  output logic             unit_position_event,
  output logic             irq
);

  // control registers
  logic [15:0]          cmp_ctl_q;
  logic [15:0]          cap_ctl_q;
  logic [31:0]          cmp_act_q;
  logic [31:0]          cmp_shd_q;
  logic                 shd_pend_q;
  logic [ECC_IRQ_W-1:0] irq_stat_q;
  logic [ECC_IRQ_W-1:0] irq_mask_q;
  ecc_apb_st_t          apb_st_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;

  // datapath registers
  logic                     eq_q;
  logic                     zero_q;
  logic                     stretch_on_q;
  logic [ECC_STRETCH_W-1:0] stretch_cnt_q;
  logic                     sync_q;
  logic                     match_q;
  logic [ECC_CAPTURE_CLOCK_PRESCALE_DIV_W-1:0] capture_clock_prescale_cnt_q;
  logic                     cap_tick_q;
  logic [ECC_UNIT_POSITION_PRESCALE_DIV_W-1:0] unit_position_prescale_cnt_q;
  logic                     upev_q;
  logic                     irq_q;

  // field views
  wire logic        shdw_en   = cmp_ctl_q[ECC_PC_SHDW_BIT];
  wire logic        load_mode = cmp_ctl_q[ECC_PC_LOAD_BIT];
  wire logic        sync_pol  = cmp_ctl_q[ECC_PC_POL_BIT];
  wire logic        cmp_en    = cmp_ctl_q[ECC_PC_EN_BIT];
  wire logic [11:0] spw       = cmp_ctl_q[ECC_PC_SPW_MSB:ECC_PC_SPW_LSB];
  wire logic        cap_en    = cap_ctl_q[ECC_CAP_EN_BIT];
  wire logic [2:0]  capture_clock_prescale      = cap_ctl_q[ECC_CAP_CAPTURE_CLOCK_PRESCALE_MSB:ECC_CAP_CAPTURE_CLOCK_PRESCALE_LSB];
  wire logic [3:0]  unit_position_prescale      = cap_ctl_q[ECC_CAP_UNIT_POSITION_PRESCALE_MSB:ECC_CAP_UNIT_POSITION_PRESCALE_LSB];

  // apb decode
  wire logic setup_ph = psel && !penable;
  wire logic wr_acc   = psel && penable && pwrite && (apb_st_q == ECC_APB_ACK);
  wire logic sel_pctl = (paddr == ECC_OFS_CMP_CTL);
  wire logic sel_cctl = (paddr == ECC_OFS_CAP_CTL);
  wire logic sel_cval = (paddr == ECC_OFS_CMP_VAL);
  wire logic sel_stat = (paddr == ECC_OFS_IRQ_STAT);
  wire logic sel_mask = (paddr == ECC_OFS_IRQ_MASK);
  wire logic sel_st   = (paddr == ECC_OFS_STATE);
  wire logic mapped   = sel_pctl | sel_cctl | sel_cval | sel_stat | sel_mask | sel_st;
  wire logic wr_ok    = wr_acc && mapped && !pslverr_q;

  // read mux, sampled in the setup cycle
  wire logic [31:0] rd_mux =
      sel_pctl ? {16'h0000, cmp_ctl_q} :
      sel_cctl ? {16'h0000, cap_ctl_q} :
      sel_cval ? cmp_act_q :
      sel_stat ? {29'h0000000, irq_stat_q} :
      sel_mask ? {29'h0000000, irq_mask_q} :
      sel_st   ? {29'h0000000, sync_q, stretch_on_q, shd_pend_q} : 32'h0000_0000;

  // apb answer: one access cycle, read data captured at the edge that ends the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_q  <= ECC_APB_IDLE;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      unique case (apb_st_q)
        ECC_APB_IDLE: begin
          if (setup_ph) begin
            apb_st_q  <= ECC_APB_ACK;
            prdata_q  <= rd_mux;
            pslverr_q <= !mapped || (pwrite && sel_st);
          end
        end
        ECC_APB_ACK: begin
          apb_st_q  <= ECC_APB_IDLE;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // compare match and shadow load conditions
  wire logic eq_now    = (position_counter == cmp_act_q);
  wire logic zero_now  = (position_counter == 32'h0000_0000);
  wire logic match_ev  = cmp_en && eq_now && !eq_q;
  wire logic load_pt   = load_mode ? (eq_now && !eq_q) : (zero_now && !zero_q);
  wire logic shd_load  = shdw_en && shd_pend_q && load_pt;
  wire logic wr_cval   = wr_ok && sel_cval;

  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ctl_q <= ECC_RST_CMP_CTL;
      cap_ctl_q <= ECC_RST_CAP_CTL;
      irq_mask_q <= ECC_RST_IRQ;
    end else begin
      if (wr_ok && sel_pctl) cmp_ctl_q <= pwdata[15:0];
      if (wr_ok && sel_cctl) cap_ctl_q <= pwdata[15:0] & ECC_CAP_WMASK;
      if (wr_ok && sel_mask) irq_mask_q <= pwdata[ECC_IRQ_W-1:0];
    end
  end

  // compare value: direct or through the shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_act_q  <= ECC_RST_CMP_VAL;
      cmp_shd_q  <= ECC_RST_CMP_VAL;
      shd_pend_q <= 1'b0;
    end else begin
      if (wr_cval && !shdw_en) cmp_act_q <= pwdata;
      else if (shd_load) cmp_act_q <= cmp_shd_q;
      if (wr_cval && shdw_en) cmp_shd_q <= pwdata;
      if (wr_cval && shdw_en) shd_pend_q <= 1'b1;
      else if (shd_load || !shdw_en) shd_pend_q <= 1'b0;
    end
  end

  // pulse stretcher next state
  wire logic [ECC_STRETCH_W-1:0] stretch_load = {spw, 2'b11};
  wire logic stretch_on_d = cmp_en && (match_ev || (stretch_on_q && stretch_cnt_q != '0));

  // stretcher, restart on every new match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_q          <= 1'b0;
      zero_q        <= 1'b0;
      stretch_on_q  <= 1'b0;
      stretch_cnt_q <= '0;
      sync_q        <= 1'b0;
      match_q       <= 1'b0;
    end else begin
      eq_q         <= eq_now;
      zero_q       <= zero_now;
      stretch_on_q <= stretch_on_d;
      match_q      <= match_ev;
      if (match_ev) stretch_cnt_q <= stretch_load;
      else if (stretch_on_q && stretch_cnt_q != '0) stretch_cnt_q <= stretch_cnt_q - 1'b1;
      sync_q       <= stretch_on_d ^ sync_pol;
    end
  end

  // capture clock prescaler: tick every 2^capture_clock_prescale system clocks
  wire logic [ECC_CAPTURE_CLOCK_PRESCALE_DIV_W-1:0] capture_clock_prescale_mask = ECC_CAPTURE_CLOCK_PRESCALE_DIV_W'((8'h01 << capture_clock_prescale) - 8'h01);
  wire logic cap_tick_d = cap_en && ((capture_clock_prescale_cnt_q & capture_clock_prescale_mask) == capture_clock_prescale_mask);

  // unit position prescaler on quadrature clock pulses
  wire logic [ECC_UNIT_POSITION_PRESCALE_DIV_W-1:0] unit_position_prescale_mask = ECC_UNIT_POSITION_PRESCALE_DIV_W'((12'h001 << unit_position_prescale) - 12'h001);
  wire logic unit_position_prescale_valid = (unit_position_prescale <= ECC_UNIT_POSITION_PRESCALE_MAX);
  wire logic upev_d = cap_en && unit_position_prescale_valid && quadrature_clock &&
                      ((unit_position_prescale_cnt_q & unit_position_prescale_mask) == unit_position_prescale_mask);

  // prescaler counters, held clear while capture is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_clock_prescale_cnt_q <= '0;
      cap_tick_q <= 1'b0;
      unit_position_prescale_cnt_q <= '0;
      upev_q     <= 1'b0;
    end else begin
      cap_tick_q <= cap_tick_d;
      upev_q     <= upev_d;
      if (!cap_en) capture_clock_prescale_cnt_q <= '0;
      else capture_clock_prescale_cnt_q <= cap_tick_d ? '0 : capture_clock_prescale_cnt_q + 1'b1;
      if (!cap_en || !unit_position_prescale_valid) unit_position_prescale_cnt_q <= '0;
      else if (quadrature_clock) unit_position_prescale_cnt_q <= upev_d ? '0 : unit_position_prescale_cnt_q + 1'b1;
    end
  end

  // sticky flags, set wins over write-one-clear
  wire logic [ECC_IRQ_W-1:0] irq_set = {upev_d, shd_load, match_ev};
  wire logic [ECC_IRQ_W-1:0] irq_clr = (wr_ok && sel_stat) ? pwdata[ECC_IRQ_W-1:0] : '0;
  wire logic [ECC_IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= ECC_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // outputs from flops
  assign prdata              = prdata_q;
  assign pready              = (apb_st_q == ECC_APB_ACK);
  assign pslverr             = pslverr_q; // only ever set while in the ack state
  assign sync_out            = sync_q;
  assign compare_match       = match_q;
  assign capture_timer_clock = cap_tick_q;
  assign unit_position_event = upev_q;
  assign irq                 = irq_q;

  // assertion helpers
  logic [ECC_STRETCH_W:0] a_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) a_len_q <= '0;
    else if (match_ev) a_len_q <= '0;
    else if (stretch_on_q && a_len_q != '1) a_len_q <= a_len_q + 1'b1;
  end

  a_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cval && !shdw_en |=> cmp_act_q == $past(pwdata))
    else $error("direct compare write not applied");

  a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cval && shdw_en && !shd_load |=> cmp_act_q == $past(cmp_act_q) && shd_pend_q)
    else $error("shadowed write reached active value early");

  a_shadow_load: assert property (@(posedge pclk) disable iff (!presetn)
    shdw_en && shd_pend_q && !wr_cval && !load_mode && zero_now && !zero_q
      |=> cmp_act_q == $past(cmp_shd_q) && irq_stat_q[ECC_IRQ_SHLD])
    else $error("shadow not loaded at counter zero");

  a_sync_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    !stretch_on_q && !match_ev && $stable(sync_pol) |=> sync_out == $past(sync_pol))
    else $error("idle sync level wrong for polarity");

  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_en |=> !compare_match && !stretch_on_q)
    else $error("compare activity while disabled");

  a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_en && stretch_on_q && !match_ev && $fell(stretch_on_d) |->
      a_len_q == {1'b0, $past(spw, 1), 2'b11} || !$stable(spw))
    else $error("stretched pulse width wrong");

  a_width_min: assert property (@(posedge pclk) disable iff (!presetn)
    match_ev ##1 cmp_en[*3] |=>
      $past(stretch_on_q, 3) && $past(stretch_on_q, 2) && $past(stretch_on_q) && stretch_on_q)
    else $error("sync pulse shorter than four cycles");

  a_capture_off: assert property (@(posedge pclk) disable iff (!presetn)
    !cap_en |=> !capture_timer_clock && !unit_position_event)
    else $error("capture outputs while capture disabled");

  a_div_one: assert property (@(posedge pclk) disable iff (!presetn)
    cap_en && capture_clock_prescale == 3'h0 |=> capture_timer_clock)
    else $error("divide by one does not tick every clock");

  a_unit_position_prescale_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    unit_position_prescale > ECC_UNIT_POSITION_PRESCALE_MAX |=> !unit_position_event)
    else $error("event from reserved prescale code");

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    match_ev |=> compare_match && irq_stat_q[ECC_IRQ_MATCH])
    else $error("match did not raise output and flag");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ctl_q[14:7] == 8'h00)
    else $error("reserved capture bits nonzero");

endmodule

// ---- verif/ecc_encoder_model.sv ----
// encoder side model: position counter and quadrature count pulses
module ecc_encoder_model (
  input  wire logic        pclk,
  output logic      [31:0] position_counter,
  output logic             quadrature_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // start away from zero and from any compare value in use
  initial begin
    position_counter = 32'h0000_0064;
    quadrature_clock = 1'b0;
  end

  // jump the counter to a new value at the next edge
  task automatic move(input logic [31:0] v);
    @(posedge pclk);
    position_counter <= v;
  endtask

  // one-cycle count pulses, one idle cycle between them
  task automatic step(input int n);
    repeat (n) begin
      @(posedge pclk);
      quadrature_clock <= 1'b1;
      position_counter <= position_counter + 32'h1;
      @(posedge pclk);
      quadrature_clock <= 1'b0;
    end
  endtask
endmodule

// ---- verif/test_ecc_top.sv ----
// self-checking bench for the compare and capture control block
module test_ecc_top
  import ecc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] position_counter;
  logic        quadrature_clock;
  logic        sync_out;
  logic        compare_match;
  logic        capture_timer_clock;
  logic        unit_position_event;
  logic        irq;
  logic        pol = 1'b0;
  int          fail_count = 0;
  int          checks = 0;
  int          n_sync = 0;
  int          n_match = 0;
  int          n_tick = 0;
  int          n_evt = 0;
  int          s0, s1, s2, s3;

  always #5 pclk = ~pclk;

  ecc_top u_ecc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .position_counter(position_counter),
    .quadrature_clock(quadrature_clock), .sync_out(sync_out),
    .compare_match(compare_match), .capture_timer_clock(capture_timer_clock),
    .unit_position_event(unit_position_event), .irq(irq));

  ecc_encoder_model u_ecc_encoder_model (.pclk(pclk), .position_counter(position_counter),
    .quadrature_clock(quadrature_clock));

  // running counts of output activity, sampled at each edge
  always @(posedge pclk) begin
    n_sync  <= n_sync + (sync_out === ~pol);
    n_match <= n_match + (compare_match === 1'b1);
    n_tick  <= n_tick + (capture_timer_clock === 1'b1);
    n_evt   <= n_evt + (unit_position_event === 1'b1);
  end

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic snap();
    repeat (40) @(posedge pclk);
    s0 = n_sync;
    s1 = n_match;
  endtask

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ECC_OFS_CMP_CTL, 32'h0, 1'b0);
    rd(ECC_OFS_CAP_CTL, 32'h0, 1'b0);
    rd(ECC_OFS_CMP_VAL, 32'h0, 1'b0);
    tend("reset");
    wr(ECC_OFS_CAP_CTL, 32'hFFFF_FFFF);
    rd(ECC_OFS_CAP_CTL, 32'h0000_807F, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    wr(ECC_OFS_CAP_CTL, 32'h0);
    tend("map");
    wr(ECC_OFS_CMP_CTL, 32'h1000);
    wr(ECC_OFS_CMP_VAL, 32'h20);
    rd(ECC_OFS_CMP_VAL, 32'h20, 1'b0);
    snap();
    u_ecc_encoder_model.move(32'h20);
    repeat (40) @(posedge pclk);
    chk(32'(n_sync - s0), 32'd4);
    chk(32'(n_match - s1), 32'd1);
    tend("width");
    // polarity low-active, width code 1, then a match that restarts the width
    wr(ECC_OFS_CMP_CTL, 32'h3001);
    pol = 1'b1;
    u_ecc_encoder_model.move(32'h64);
    snap();
    s2 = n_match;
    u_ecc_encoder_model.move(32'h20);
    u_ecc_encoder_model.move(32'h64);
    u_ecc_encoder_model.move(32'h20);
    repeat (40) @(posedge pclk);
    chk(32'(n_sync - s0), 32'd10);
    chk({31'h0, sync_out}, 32'h1);
    s3 = n_sync;
    chk(32'(n_match - s2), 32'd2);
    tend("restart");
    wr(ECC_OFS_CMP_CTL, 32'h2001);
    u_ecc_encoder_model.move(32'h64);
    snap();
    u_ecc_encoder_model.move(32'h20);
    repeat (40) @(posedge pclk);
    chk(32'(n_sync - s0), 32'd0);
    chk(32'(n_match - s1), 32'd0);
    tend("disable");
    wr(ECC_OFS_CMP_CTL, 32'h9000);
    pol = 1'b0;
    wr(ECC_OFS_CMP_VAL, 32'h30);
    rd(ECC_OFS_CMP_VAL, 32'h20, 1'b0);
    u_ecc_encoder_model.move(32'h0);
    snap();
    rd(ECC_OFS_CMP_VAL, 32'h30, 1'b0);
    wr(ECC_OFS_CMP_CTL, 32'hD000);
    wr(ECC_OFS_CMP_VAL, 32'h40);
    u_ecc_encoder_model.move(32'h30);
    snap();
    rd(ECC_OFS_CMP_VAL, 32'h40, 1'b0);
    rd(ECC_OFS_IRQ_STAT, 32'h3, 1'b0);
    tend("shadow");
    wr(ECC_OFS_IRQ_STAT, 32'h7);
    wr(ECC_OFS_IRQ_MASK, 32'h1);
    u_ecc_encoder_model.move(32'h40);
    snap();
    chk({31'h0, irq}, 32'h1);
    rd(ECC_OFS_IRQ_STAT, 32'h1, 1'b0);
    wr(ECC_OFS_IRQ_MASK, 32'h0);
    snap();
    chk({31'h0, irq}, 32'h0);
    wr(ECC_OFS_IRQ_MASK, 32'h1);
    wr(ECC_OFS_IRQ_STAT, 32'h1);
    snap();
    chk({31'h0, irq}, 32'h0);
    rd(ECC_OFS_IRQ_STAT, 32'h0, 1'b0);
    tend("irq");
    wr(ECC_OFS_CAP_CTL, 32'h8030);
    snap();
    s2 = n_tick;
    repeat (64) @(posedge pclk);
    chk(32'(n_tick - s2), 32'd8);
    wr(ECC_OFS_CAP_CTL, 32'h8070);
    snap();
    s2 = n_tick;
    repeat (256) @(posedge pclk);
    chk(32'(n_tick - s2), 32'd2);
    wr(ECC_OFS_CAP_CTL, 32'h0030);
    snap();
    s2 = n_tick;
    repeat (64) @(posedge pclk);
    chk(32'(n_tick - s2), 32'd0);
    tend("capture clock");
    wr(ECC_OFS_CAP_CTL, 32'h8002);
    s2 = n_evt;
    u_ecc_encoder_model.step(8);
    snap();
    chk(32'(n_evt - s2), 32'd2);
    wr(ECC_OFS_CAP_CTL, 32'h800C);
    s2 = n_evt;
    u_ecc_encoder_model.step(8);
    snap();
    chk(32'(n_evt - s2), 32'd0);
    tend("unit event");
    finish_test();
  end
endmodule
